// *** oas_pkg.sv ***
package oas_pkg;
    // ==========================================
    // modes, sizes and operand kinds
    typedef enum logic [2:0] {
        OAS_REAL,
        OAS_V86,
        OAS_SYS_MGMT,
        OAS_PROT,
        OAS_COMPAT,
        OAS_LONG
    } oas_mode_e;
    typedef enum logic [1:0] {OAS_SZ16, OAS_SZ32, OAS_SZ64} oas_size_e;
    typedef enum logic [1:0] {OAS_OP_ARITH, OAS_OP_DIV, OAS_OP_OTHER} oas_op_e;
    typedef enum logic [1:0] {
        OAS_DST_REG,
        OAS_DST_MEM,
        OAS_DST_IO,
        OAS_DST_IMM
    } oas_dst_e;
    typedef enum logic [1:0] {OAS_RC_GPR, OAS_RC_VEC, OAS_RC_CTL} oas_rc_e;

    // ==========================================
    // front end to decoder
    typedef struct packed {
        logic        p66;
        logic        p67;
        logic        ext_pres;
        logic [3:0]  ext_pfx;
        logic        mand_pfx;
        logic [3:0]  len;
        logic        ip_rel;
        logic [31:0] disp;
        logic        imm_pres;
        logic [63:0] imm;
        oas_op_e     op;
        oas_dst_e    dst;
        oas_rc_e     rcls;
        logic [3:0]  reg_idx;
        logic        byte_op;
        logic        pair_op;
    } oas_instr_s;

    // decoder to execution datapath
    typedef struct packed {
        oas_size_e   op_size;
        oas_size_e   addr_size;
        logic [7:0]  op_bits;
        logic [63:0] ea;
        logic [63:0] next_ip;
        logic        byte_high;
        logic [3:0]  pair_hi;
        logic [3:0]  pair_lo;
        logic [7:0]  pair_bits;
        logic        err_imm;
        logic        err_dst;
        logic        err_reg;
    } oas_dec_s;

    // ==========================================
    // register map and fields
    localparam logic [7:0]  OAS_CTRL_ADR  = 8'h00;
    localparam logic [7:0]  OAS_NIPL_ADR  = 8'h04;
    localparam logic [7:0]  OAS_NIPH_ADR  = 8'h08;
    localparam logic [7:0]  OAS_STAT_ADR  = 8'h0C;
    localparam int          OAS_DFLAG_BIT = 3;
    localparam int          OAS_ST_OPSZ   = 0;
    localparam int          OAS_ST_ADSZ   = 2;
    localparam int          OAS_ST_P66    = 4;
    localparam int          OAS_ST_P67    = 5;
    localparam int          OAS_ST_W      = 6;
    localparam int          OAS_ST_ERR    = 7;
    localparam int          OAS_ST_VALID  = 8;
    localparam logic [63:0] OAS_NIP_RST   = 64'h0;

    // ==========================================
    // prefix fields, limits, widths, register sets
    localparam int          OAS_EXT_W    = 3;
    localparam logic [63:0] OAS_IMM_MAX  = 64'h0000_0000_FFFF_FFFF;
    localparam logic [63:0] OAS_MASK16   = 64'h0000_0000_0000_FFFF;
    localparam logic [63:0] OAS_MASK32   = 64'h0000_0000_FFFF_FFFF;
    localparam logic [63:0] OAS_MASK64   = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [3:0]  OAS_PAIR_HI  = 4'h2;
    localparam logic [3:0]  OAS_PAIR_LO  = 4'h0;
    localparam logic [7:0]  OAS_W8       = 8'h08;
    localparam logic [7:0]  OAS_W16      = 8'h10;
    localparam logic [7:0]  OAS_W32      = 8'h20;
    localparam logic [7:0]  OAS_W64      = 8'h40;
    localparam logic [7:0]  OAS_W128     = 8'h80;
    localparam logic [15:0] OAS_CR_LEG   = 16'h001D;
    localparam logic [15:0] OAS_CR_LONG  = 16'h011D;
endpackage

// *** oas_size_sel.sv ***
module oas_size_sel
    import oas_pkg::*;
(
    input  wire oas_mode_e mode_i,
    input  wire logic      dflag_i,
    input  wire logic      p66_i,
    input  wire logic      p67_i,
    input  wire logic      wide_i,
    input  wire logic      mand_i,
    output oas_size_e      op_size_o,
    output oas_size_e      addr_size_o
);
    logic opt;

    // mandatory 66 byte is an opcode extension, not a size override
    assign opt = p66_i && !mand_i;

    always_comb begin
        unique case (mode_i)
            OAS_LONG: begin
                addr_size_o = p67_i ? OAS_SZ32 : OAS_SZ64;
                if (wide_i) begin
                    op_size_o = OAS_SZ64;
                end else if (opt) begin
                    op_size_o = OAS_SZ16;
                end else begin
                    op_size_o = OAS_SZ32;
                end
            end
            OAS_PROT, OAS_COMPAT: begin
                op_size_o   = (dflag_i ^ opt) ? OAS_SZ32 : OAS_SZ16;
                addr_size_o = (dflag_i ^ p67_i) ? OAS_SZ32 : OAS_SZ16;
            end
            OAS_REAL, OAS_V86, OAS_SYS_MGMT: begin
                op_size_o   = opt ? OAS_SZ32 : OAS_SZ16;
                addr_size_o = p67_i ? OAS_SZ32 : OAS_SZ16;
            end
            default: begin
                op_size_o   = OAS_SZ16;
                addr_size_o = OAS_SZ16;
            end
        endcase
    end
endmodule

// *** oas_reg_chk.sv ***
module oas_reg_chk
    import oas_pkg::*;
(
    input  wire logic       long_i,
    input  wire logic       ext_i,
    input  wire logic       byte_i,
    input  wire oas_rc_e    rcls_i,
    input  wire logic [3:0] idx_i,
    output logic            legal_o,
    output logic            byte_high_o
);
    always_comb begin
        byte_high_o = 1'b0;
        unique case (rcls_i)
            OAS_RC_GPR: begin
                // extended set only with the extension prefix
                legal_o = !idx_i[3] || (long_i && ext_i);
                // slots 4..7 are high bytes unless the prefix is present
                byte_high_o = byte_i && idx_i[2] && !idx_i[3]
                              && !(long_i && ext_i);
            end
            OAS_RC_VEC: begin
                legal_o = !idx_i[3] || long_i;
            end
            OAS_RC_CTL: begin
                legal_o = long_i ? OAS_CR_LONG[idx_i]
                                 : OAS_CR_LEG[idx_i];
            end
            default: begin
                legal_o = 1'b0;
            end
        endcase
    end
endmodule

// *** oas_decoder.sv ***
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
module oas_decoder
    import oas_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        in_valid_i,
    input  wire oas_instr_s  in_instr_i,
    output logic             in_ready_o,
    output logic             out_valid_o,
    output oas_dec_s         out_dec_o,
    input  wire logic        out_ready_i
);
    // ==========================================
    // state
    oas_mode_e   mode;
    logic        dflag;
    logic [63:0] nip;
    logic        lat_66;
    logic        lat_67;
    logic        lat_w;
    oas_dec_s    dec;
    logic        dec_valid;

    // ==========================================
    // handshake
    logic        acc;
    logic        bnd;
    logic        wb_req;
    logic        wb_wr;

    assign in_ready_o  = !dec_valid || out_ready_i;
    assign acc         = in_valid_i && in_ready_o;
    assign bnd         = dec_valid && out_ready_i;
    assign out_valid_o = dec_valid;
    assign out_dec_o   = dec;
    assign wb_req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr       = wb_req && wb_we_i;

    // ==========================================
    // prefix decode
    logic        is_long;
    logic        ext_on;
    logic        wide;

    assign is_long = (mode == OAS_LONG);
    // extension prefix only exists in long mode
    assign ext_on  = is_long && in_instr_i.ext_pres;
    assign wide    = ext_on && in_instr_i.ext_pfx[OAS_EXT_W];

    oas_size_e   op_sz;
    oas_size_e   ad_sz;
    oas_size_e   dflt_op;
    oas_size_e   dflt_ad;

    oas_size_sel u_eff (
        .mode_i      (mode),
        .dflag_i     (dflag),
        .p66_i       (in_instr_i.p66),
        .p67_i       (in_instr_i.p67),
        .wide_i      (wide),
        .mand_i      (in_instr_i.mand_pfx),
        .op_size_o   (op_sz),
        .addr_size_o (ad_sz)
    );

    // code segment defaults, no prefix applied
    oas_size_sel u_dflt (
        .mode_i      (mode),
        .dflag_i     (dflag),
        .p66_i       (1'b0),
        .p67_i       (1'b0),
        .wide_i      (1'b0),
        .mand_i      (1'b0),
        .op_size_o   (dflt_op),
        .addr_size_o (dflt_ad)
    );

    logic        reg_ok;
    logic        byte_hi;

    oas_reg_chk u_reg (
        .long_i      (is_long),
        .ext_i       (ext_on),
        .byte_i      (in_instr_i.byte_op),
        .rcls_i      (in_instr_i.rcls),
        .idx_i       (in_instr_i.reg_idx),
        .legal_o     (reg_ok),
        .byte_high_o (byte_hi)
    );

    // ==========================================
    // address and width arithmetic
    logic [63:0] ip_mask;
    logic [63:0] ad_mask;
    logic [63:0] disp_x;
    logic [63:0] next_ip;
    logic [63:0] ea;
    logic [7:0]  full_bits;

    always_comb begin
        unique case (dflt_ad)
            OAS_SZ16: ip_mask = OAS_MASK16;
            OAS_SZ32: ip_mask = OAS_MASK32;
            OAS_SZ64: ip_mask = OAS_MASK64;
            default:  ip_mask = OAS_MASK16;
        endcase
        unique case (ad_sz)
            OAS_SZ16: ad_mask = OAS_MASK16;
            OAS_SZ32: ad_mask = OAS_MASK32;
            OAS_SZ64: ad_mask = OAS_MASK64;
            default:  ad_mask = OAS_MASK16;
        endcase
        unique case (op_sz)
            OAS_SZ16: full_bits = OAS_W16;
            OAS_SZ32: full_bits = OAS_W32;
            OAS_SZ64: full_bits = OAS_W64;
            default:  full_bits = OAS_W16;
        endcase
    end

    assign disp_x  = {{32{in_instr_i.disp[31]}}, in_instr_i.disp};
    assign next_ip = (nip + {60'h0, in_instr_i.len}) & ip_mask;
    // pointer-relative form uses the following instruction's address
    assign ea = (is_long && in_instr_i.ip_rel)
              ? next_ip + disp_x
              : disp_x & ad_mask;

    // ==========================================
    // decode result register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_valid <= 1'b0;
        end else if (acc) begin
            dec_valid <= 1'b1;
        end else if (bnd) begin
            dec_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec <= '0;
        end else if (acc) begin
            dec.op_size   <= op_sz;
            dec.addr_size <= ad_sz;
            dec.op_bits   <= in_instr_i.byte_op ? OAS_W8
                                                : full_bits;
            dec.ea        <= ea;
            dec.next_ip   <= next_ip;
            dec.byte_high <= byte_hi;
            dec.pair_hi   <= OAS_PAIR_HI;
            dec.pair_lo   <= OAS_PAIR_LO;
            dec.pair_bits <= !in_instr_i.pair_op ? 8'h00
                           : (op_sz == OAS_SZ64) ? OAS_W128
                           : (op_sz == OAS_SZ32) ? OAS_W64
                           : OAS_W32;
            dec.err_imm   <= in_instr_i.imm_pres
                             && (in_instr_i.op == OAS_OP_DIV
                             || in_instr_i.imm > OAS_IMM_MAX);
            dec.err_dst   <= in_instr_i.dst == OAS_DST_IMM;
            dec.err_reg   <= !reg_ok;
        end
    end

    // ==========================================
    // per instruction prefix latches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_66 <= 1'b0;
            lat_67 <= 1'b0;
            lat_w  <= 1'b0;
        end else if (acc) begin
            lat_66 <= in_instr_i.p66;
            lat_67 <= in_instr_i.p67;
            lat_w  <= wide;
        end else if (bnd) begin
            // nothing carries into the next instruction
            lat_66 <= 1'b0;
            lat_67 <= 1'b0;
            lat_w  <= 1'b0;
        end
    end

    // ==========================================
    // control register and instruction pointer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode  <= OAS_REAL;
            dflag <= 1'b0;
        end else if (wb_wr && wb_adr_i == OAS_CTRL_ADR && wb_sel_i[0]) begin
            mode  <= oas_mode_e'(wb_dat_i[2:0]);
            dflag <= wb_dat_i[OAS_DFLAG_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nip <= OAS_NIP_RST;
        end else if (wb_wr && wb_adr_i == OAS_NIPL_ADR) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    nip[8*b +: 8] <= wb_dat_i[8*b +: 8];
                end
            end
        end else if (wb_wr && wb_adr_i == OAS_NIPH_ADR) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    nip[32 + 8*b +: 8] <= wb_dat_i[8*b +: 8];
                end
            end
        end else if (acc) begin
            nip <= next_ip;
        end
    end

    // ==========================================
    // bus read path
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0;
        unique case (wb_adr_i)
            OAS_CTRL_ADR: begin
                rd_mux[2:0]           = mode;
                rd_mux[OAS_DFLAG_BIT] = dflag;
            end
            OAS_NIPL_ADR: rd_mux = nip[31:0];
            OAS_NIPH_ADR: rd_mux = nip[63:32];
            OAS_STAT_ADR: begin
                rd_mux[OAS_ST_OPSZ +: 2] = dec.op_size;
                rd_mux[OAS_ST_ADSZ +: 2] = dec.addr_size;
                rd_mux[OAS_ST_P66]       = lat_66;
                rd_mux[OAS_ST_P67]       = lat_67;
                rd_mux[OAS_ST_W]         = lat_w;
                rd_mux[OAS_ST_ERR]       = dec.err_imm || dec.err_dst
                                           || dec.err_reg;
                rd_mux[OAS_ST_VALID]     = dec_valid;
            end
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= (wb_req && !wb_we_i) ? rd_mux : 32'h0;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic        no_nip_wr;
    assign no_nip_wr = !(wb_wr && (wb_adr_i == OAS_NIPL_ADR
                                || wb_adr_i == OAS_NIPH_ADR));

    long_addr_a: assert property (
        acc && is_long |=> dec.addr_size ==
            ($past(in_instr_i.p67) ? OAS_SZ32 : OAS_SZ64))
        else $error("long mode address size wrong");

    wide_op_a: assert property (
        acc && wide |=> dec.op_size == OAS_SZ64 && lat_w)
        else $error("wide bit did not force 64-bit operand");

    long_half_a: assert property (
        acc && is_long && !wide && in_instr_i.p66
        && !in_instr_i.mand_pfx |=> dec.op_size == OAS_SZ16)
        else $error("66 prefix in long mode not 16-bit");

    legacy_dflt_a: assert property (
        acc && (mode == OAS_REAL || mode == OAS_V86 || mode == OAS_SYS_MGMT)
        && !in_instr_i.p66 && !in_instr_i.p67
        |=> dec.op_size == OAS_SZ16 && dec.addr_size == OAS_SZ16)
        else $error("legacy mode default not 16-bit");

    prot_toggle_a: assert property (
        acc && (mode == OAS_PROT || mode == OAS_COMPAT)
        && !in_instr_i.mand_pfx
        |=> (dec.op_size == OAS_SZ32)
            == ($past(dflag) ^ $past(in_instr_i.p66))
        && (dec.addr_size == OAS_SZ32)
            == ($past(dflag) ^ $past(in_instr_i.p67)))
        else $error("prefix toggle wrong");

    nip_adv_a: assert property (
        acc && is_long && no_nip_wr
        |=> nip == $past(nip) + {60'h0, $past(in_instr_i.len)}
        && dec.next_ip == nip)
        else $error("instruction pointer did not advance");

    iprel_ea_a: assert property (
        acc && is_long && in_instr_i.ip_rel
        |=> dec.ea == dec.next_ip + {{32{$past(in_instr_i.disp[31])}},
                                      $past(in_instr_i.disp)})
        else $error("pointer-relative address wrong");

    imm_lim_a: assert property (
        acc && in_instr_i.imm_pres && in_instr_i.imm[63:32] != 32'h0
        |=> dec.err_imm)
        else $error("oversize immediate accepted");

    dst_imm_a: assert property (
        acc |=> dec.err_dst == ($past(in_instr_i.dst) == OAS_DST_IMM))
        else $error("immediate destination not flagged");

    pfx_clear_a: assert property (
        bnd && !acc |=> !lat_66 && !lat_67 && !lat_w && !dec_valid)
        else $error("prefix latch survived boundary");

    pair_wide_a: assert property (
        acc && wide && in_instr_i.pair_op
        |=> dec.pair_bits == OAS_W128 && dec.pair_hi == OAS_PAIR_HI)
        else $error("wide pair not 128-bit");

    ack_once_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    long_wide_c: cover property (acc && wide && in_instr_i.p66);
    prot_both_c: cover property (acc && mode == OAS_PROT
                                 && in_instr_i.p66 && in_instr_i.p67);
    stall_c: cover property (dec_valid && !out_ready_i && in_valid_i);
    b2b_c: cover property (acc ##1 acc);
endmodule

// *** oas_fe_model.sv ***
module oas_fe_model
    import oas_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       in_ready_i,
    input  wire logic       push_i,
    input  wire oas_instr_s push_instr_i,
    output logic            in_valid_o,
    output oas_instr_s      in_instr_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================
    // offer held until the decoder takes it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_valid_o <= 1'b0;
            in_instr_o <= '0;
        end else if (push_i) begin
            in_valid_o <= 1'b1;
            in_instr_o <= push_instr_i;
        end else if (in_valid_o && in_ready_i) begin
            in_valid_o <= 1'b0;
            // released: no stale value left on the lines
            in_instr_o <= ~in_instr_o;
        end
    end
endmodule

// *** oas_decoder_tb_top.sv ***
module oas_decoder_tb_top;
    import oas_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_i, rst_i, cyc, stb, we, ack, in_v, in_r, out_v;
    logic        out_r, push, df;
    logic [7:0]  adr;
    logic [2:0]  md, xerr;
    logic [31:0] wdat, rdat, rv, seed;
    logic [31:0] rseed = 32'hE5836E2B;
    logic [63:0] nip;
    oas_instr_s  pi, ii, r;
    oas_dec_s    dec;
    int          mismatches, compares;

    oas_decoder uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .in_valid_i(in_v),
        .in_instr_i(ii), .in_ready_o(in_r), .out_valid_o(out_v),
        .out_dec_o(dec), .out_ready_i(out_r));
    oas_fe_model fe (.clk_i(clk_i), .rst_i(rst_i), .in_ready_i(in_r),
        .push_i(push), .push_instr_i(pi), .in_valid_o(in_v),
        .in_instr_o(ii));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // ==========================================
    // expectations
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [63:0] msk(input oas_size_e s);
        return s == OAS_SZ16 ? OAS_MASK16 : s == OAS_SZ32 ? OAS_MASK32
            : OAS_MASK64;
    endfunction
    function automatic logic [7:0] wid(input oas_size_e s);
        return s == OAS_SZ16 ? OAS_W16 : s == OAS_SZ32 ? OAS_W32 : OAS_W64;
    endfunction
    function automatic logic dw();
        return df && (md == 3'd3 || md == 3'd4);
    endfunction
    function automatic oas_size_e xop(input oas_instr_s i);
        logic t;
        t = i.p66 && !i.mand_pfx;
        if (md == 3'd5)
            return (i.ext_pres && i.ext_pfx[OAS_EXT_W]) ? OAS_SZ64
                : t ? OAS_SZ16 : OAS_SZ32;
        return (dw() ^ t) ? OAS_SZ32 : OAS_SZ16;
    endfunction
    function automatic oas_size_e xad(input oas_instr_s i);
        if (md == 3'd5)
            return i.p67 ? OAS_SZ32 : OAS_SZ64;
        return (dw() ^ i.p67) ? OAS_SZ32 : OAS_SZ16;
    endfunction

    // ==========================================
    // shared tasks
    task automatic chk(input logic ok, input string m);
        compares++;
        if (!ok) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // no assumed latency: only the watchdog ends this wait
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rv = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic setm(input logic [2:0] m, input logic d);
        md = m;
        df = d;
        wb(1'b1, OAS_CTRL_ADR, {28'h0, d, m});
    endtask
    task automatic run(input oas_instr_s i);
        oas_size_e   so, sa;
        logic [63:0] nx, ea, sx;
        logic [7:0]  xp;
        int          n;
        so = xop(i);
        sa = xad(i);
        sx = {{32{i.disp[31]}}, i.disp};
        nx = (nip + 64'(i.len)) & (md == 3'd5 ? OAS_MASK64
            : dw() ? OAS_MASK32 : OAS_MASK16);
        ea = i.ip_rel ? nx + sx : sx & msk(sa);
        xp = !i.pair_op ? 8'h00 : so == OAS_SZ16 ? OAS_W32
            : so == OAS_SZ32 ? OAS_W64 : OAS_W128;
        pi <= i;
        push <= 1'b1;
        @(posedge clk_i);
        push <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (out_v && !out_r)
                chk(in_r === 1'b0, "taken while result held");
        end while (!(out_v && out_r) && n < 50);
        chk((out_v && out_r) === 1'b1, "result timeout");
        chk(dec.op_size === so, "operand size");
        chk(dec.addr_size === sa, "address size");
        chk(dec.op_bits === (i.byte_op ? OAS_W8 : wid(so)), "width");
        chk(dec.ea === ea, "effective address");
        chk(dec.next_ip === nx, "next pointer");
        chk(dec.byte_high === (i.byte_op && i.rcls == OAS_RC_GPR
            && i.reg_idx[3:2] == 2'b01 && !(md == 3'd5 && i.ext_pres)),
            "high byte slot");
        chk({dec.err_imm, dec.err_dst, dec.err_reg} === xerr, "errors");
        chk(dec.pair_bits === xp, "pair width");
        if (i.pair_op)
            chk(dec.pair_hi === OAS_PAIR_HI && dec.pair_lo === OAS_PAIR_LO,
                "pair order");
        nip = nx;
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================
    // datapath stalls at random
    always @(posedge clk_i) begin
        rseed <= xs(rseed);
        out_r <= rst_i | (|rseed[1:0]);
    end

    initial begin
        repeat (30000) @(posedge clk_i);
        mismatches++;
        end_of_test();
    end

    // ==========================================
    // main sequence
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, push, df} = '0;
        {adr, wdat, md, xerr, nip} = '0;
        pi = '0;
        seed = 32'hE5836E2B;
        mismatches = 0;
        compares = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, OAS_CTRL_ADR, 32'h0);
        chk(rv === 32'h0, "control reset");
        wb(1'b0, OAS_NIPH_ADR, 32'h0);
        chk(rv === OAS_NIP_RST[63:32], "pointer reset");
        wb(1'b1, 8'h10, 32'hFFFF_FFFF);
        wb(1'b0, 8'h10, 32'h0);
        chk(rv === 32'h0, "unmapped read");
        for (int k = 0; k < 120; k++) begin
            if (k % 8 == 0) begin
                seed = xs(seed);
                setm(3'(seed[7:0] % 8'h06), seed[8]);
            end
            seed = xs(seed);
            r = '0;
            {r.p66, r.p67, r.ext_pres, r.ext_pfx, r.mand_pfx} = seed[7:0];
            r.len = 4'(seed[11:8] % 4'hF) + 4'h1;
            r.ip_rel = md == 3'd5 && seed[12];
            r.reg_idx = {1'b0, seed[15:13]};
            r.byte_op = seed[16];
            r.disp = xs(seed);
            run(r);
        end
        wb(1'b0, OAS_STAT_ADR, 32'h0);
        chk(rv[8:4] === 5'h00, "latches cleared");
        setm(3'd5, 1'b1);
        wb(1'b1, OAS_NIPL_ADR, 32'hFFFF_FFFE);
        wb(1'b1, OAS_NIPH_ADR, 32'h0);
        nip = 64'h0000_0000_FFFF_FFFE;
        r = '0;
        r.len = 4'h4;
        r.ip_rel = 1'b1;
        r.disp = 32'hFFFF_FFF0;
        run(r);
        wb(1'b0, OAS_NIPH_ADR, 32'h0);
        chk(rv === 32'h1, "pointer carry");
        r.ip_rel = 1'b0;
        r.op = OAS_OP_DIV;
        r.imm_pres = 1'b1;
        r.imm = 64'h5;
        xerr = 3'b100;
        run(r);
        r.op = OAS_OP_ARITH;
        r.imm = OAS_IMM_MAX;
        xerr = 3'b000;
        run(r);
        r.imm = OAS_IMM_MAX + 64'h1;
        xerr = 3'b100;
        run(r);
        r.imm_pres = 1'b0;
        r.dst = OAS_DST_IMM;
        xerr = 3'b010;
        run(r);
        r.dst = OAS_DST_REG;
        r.reg_idx = 4'h9;
        xerr = 3'b001;
        run(r);
        r.ext_pres = 1'b1;
        r.ext_pfx = 4'h8;
        r.pair_op = 1'b1;
        xerr = 3'b000;
        run(r);
        r.pair_op = 1'b0;
        r.rcls = OAS_RC_CTL;
        r.reg_idx = 4'h8;
        run(r);
        setm(3'd3, 1'b1);
        xerr = 3'b001;
        run(r);
        r.rcls = OAS_RC_VEC;
        r.reg_idx = 4'hF;
        run(r);
        r = '0;
        r.len = 4'h1;
        r.pair_op = 1'b1;
        xerr = 3'b000;
        run(r);
        end_of_test();
    end
endmodule
